// [bench/testbench.sv]
// Self-checking testbench for the OR, return and rotate execution unit.
`timescale 1ns/1ps
module testbench
  import orre_pkg::*;
;
  logic clk, rst_n, valid, irq, int_en_clr, push;
  logic [2:0] code;
  logic [7:0] imm, addr, rdata;
  logic [12:0] vec, push_pc;
  logic ready, done, zero, int_en, pc_load, irq_take, re, we;
  logic [7:0] acc, maddr, wdata;
  logic [12:0] pc;
  logic [2:0] sp;
  int n_fail = 0;
  int cmp_count = 0;
  logic saw_re;

  orre_exec orre_exec_i (.CLOCK_IN(clk), .RST_N_IN(rst_n),
    .OP_VALID_IN(valid), .OP_CODE_IN(code), .OP_IMM_IN(imm),
    .OP_ADDR_IN(addr), .MEM_RDATA_IN(rdata), .IRQ_PENDING_IN(irq),
    .IRQ_VECTOR_IN(vec), .INT_EN_CLEAR_IN(int_en_clr), .PUSH_IN(push),
    .PUSH_PC_IN(push_pc), .OP_READY_OUT(ready), .DONE_OUT(done),
    .ACC_OUT(acc), .ZERO_OUT(zero), .INT_EN_OUT(int_en), .PC_OUT(pc),
    .PC_LOAD_OUT(pc_load), .IRQ_TAKE_OUT(irq_take), .MEM_ADDR_OUT(maddr),
    .MEM_RE_OUT(re), .MEM_WE_OUT(we), .MEM_WDATA_OUT(wdata), .SP_OUT(sp));

  // The clock runs at 10 MHz.
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  // Compares one observed value with its expectation.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Lets one edge pass, then waits, bounded, until the unit is idle.
  // The passed edge keeps a strobe from being lowered and raised at once.
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (ready !== 1'h1 && n < 20);
  endtask

  // Offers one instruction once idle and waits, bounded, for completion.
  // Read data is held from the offer, then inverted so stale use shows.
  task automatic exec(input orre_op_t op, input logic [7:0] i,
                      input logic [7:0] a, input logic [7:0] rd);
    int n;
    n = 0;
    wait_idle();
    valid = 1'h1;
    code = op;
    imm = i;
    addr = a;
    rdata = rd;
    saw_re = 1'h0;
    @(posedge clk);
    #1;
    valid = 1'h0;
    n = 0;
    while (done !== 1'h1 && n < 10) begin
      if (re === 1'h1 && maddr === a) saw_re = 1'h1;
      @(posedge clk);
      #1;
      n++;
    end
    chk(done, 1'h1);
    rdata = ~rd;
  endtask

  // Pushes one return address while the unit is idle.
  task automatic do_push(input logic [12:0] ra);
    wait_idle();
    push = 1'h1;
    push_pc = ra;
    @(posedge clk);
    #1;
    push = 1'h0;
  endtask

  // OR with immediate, including a zero result and back-to-back use.
  task automatic t_or_imm();
    exec(ORRE_OP_OR_IMM, 8'h00, 8'h00, 8'h00);
    chk(acc, 8'h00);
    chk(zero, 1'h1);
    exec(ORRE_OP_OR_IMM, 8'h5a, 8'h00, 8'h00);
    chk(acc, 8'h5a);
    chk(zero, 1'h0);
    exec(ORRE_OP_OR_IMM, 8'h81, 8'h00, 8'h00);
    chk(acc, 8'hdb);
    chk(we, 1'h0);
    // Unused codes complete at once and leave every state alone.
    exec(orre_op_t'(3'h6), 8'hff, 8'h00, 8'h00);
    chk({acc, zero, we, sp}, {8'hdb, 1'h0, 1'h0, 3'h0});
    $display("test or_imm done");
  endtask

  // Memory ops: OR into memory and rotate, each read then written back.
  task automatic t_mem();
    exec(ORRE_OP_OR_INTO_MEMORY, 8'h00, 8'h3c, 8'h24);
    chk({saw_re, we, maddr}, {2'h3, 8'h3c});
    chk(wdata, 8'hff);
    chk({acc, zero}, {8'hdb, 1'h0});
    exec(ORRE_OP_ROTATE_LEFT, 8'h00, 8'hc5, 8'h96);
    chk({saw_re, we, maddr}, {2'h3, 8'hc5});
    chk(wdata, 8'h2d);
    chk({acc, zero}, {8'hdb, 1'h0});
    exec(ORRE_OP_ROTATE_LEFT, 8'h00, 8'hff, 8'h80);
    chk(wdata, 8'h01);
    $display("test mem done");
  endtask

  // Nested returns unwind the stack one entry at a time.
  task automatic t_returns();
    do_push(13'h0123);
    do_push(13'h0456);
    do_push(13'h1abc);
    chk(sp, 3'h3);
    exec(ORRE_OP_SUBROUTINE_EXIT, 8'h77, 8'h00, 8'h00);
    chk({pc_load, pc}, {1'h1, 13'h1abc});
    chk({sp, acc, zero}, {3'h2, 8'hdb, 1'h0});
    exec(ORRE_OP_SUBROUTINE_EXIT_IMM, 8'h00, 8'h00, 8'h00);
    chk({pc_load, pc}, {1'h1, 13'h0456});
    chk({sp, acc, zero}, {3'h1, 8'h00, 1'h0});
    // Accumulator now zero, so an OR into a zero byte must set the flag.
    exec(ORRE_OP_OR_INTO_MEMORY, 8'h00, 8'h10, 8'h00);
    chk({wdata, zero, acc}, {8'h00, 1'h1, 8'h00});
    exec(ORRE_OP_INTERRUPT_EXIT, 8'h00, 8'h00, 8'h00);
    chk({pc_load, pc, irq_take}, {1'h1, 13'h0123, 1'h0});
    chk({int_en, sp, zero}, {1'h1, 3'h0, 1'h1});
    $display("test returns done");
  endtask

  // A pending request at interrupt exit is taken before the main program.
  task automatic t_irq();
    int_en_clr = 1'h1;
    @(posedge clk);
    #1;
    int_en_clr = 1'h0;
    @(posedge clk);
    #1;
    chk(int_en, 1'h0);
    do_push(13'h0777);
    irq = 1'h1;
    vec = 13'h1f00;
    exec(ORRE_OP_INTERRUPT_EXIT, 8'h00, 8'h00, 8'h00);
    chk({irq_take, pc}, {1'h1, 13'h1f00});
    chk({int_en, sp}, {1'h1, 3'h1});
    irq = 1'h0;
    exec(ORRE_OP_SUBROUTINE_EXIT, 8'h00, 8'h00, 8'h00);
    chk({pc, sp}, {13'h0777, 3'h0});
    $display("test irq done");
  endtask

  // Main sequence: reset for 20 cycles, check reset values, run tests.
  initial begin
    {rst_n, valid, irq, int_en_clr, push} = 5'h00;
    {code, imm, addr, rdata} = 27'h0000000;
    vec = 13'h0000;
    push_pc = 13'h0000;
    repeat (20) @(posedge clk);
    chk({ready, acc, zero, int_en, pc, sp}, 27'h0000000);
    #1;
    rst_n = 1'h1;
    t_or_imm();
    t_mem();
    t_returns();
    t_irq();
    summarize();
  end

  // Watchdog: the tests need well under 500 cycles.
  initial begin
    #500000;
    n_fail++;
    summarize();
  end
endmodule // testbench

// [logic/orre_exec.sv]
// Execution unit for OR, subroutine/interrupt return and rotate-left.
`timescale 1ns/1ps
// Function
// RULE1 - OR immediate: accumulator gets accumulator OR immediate; only zero flag.
// RULE2 - or_into_memory: memory byte gets accumulator OR byte; zero flag updated.
// RULE3 - or_into_memory leaves the accumulator unchanged.
// RULE4 - subroutine_exit loads PC from stack top; no flag changes.
// RULE5 - Exit with immediate also loads immediate into accumulator; no flags.
// RULE6 - interrupt_exit restores PC and sets master_interrupt_enable to 1.
// RULE7 - Pending interrupt at interrupt_exit is serviced before main program.
// RULE8 - rotate_left moves each bit up one, bit 7 into bit 0.
// RULE9 - rotate_left writes memory back; accumulator and flags unchanged.
// RULE10 - Each return pops exactly one stack entry.
module orre_exec
  import orre_pkg::*;
#(
  parameter int ADDR_W = ORRE_ADDR_W,
  parameter int PC_W = ORRE_PC_W,
  parameter int STACK_DEPTH = ORRE_STACK_DEPTH
) (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic OP_VALID_IN,
  input wire logic [2:0] OP_CODE_IN,
  input wire logic [7:0] OP_IMM_IN,
  input wire logic [ADDR_W-1:0] OP_ADDR_IN,
  input wire logic [7:0] MEM_RDATA_IN,
  input wire logic IRQ_PENDING_IN,
  input wire logic [PC_W-1:0] IRQ_VECTOR_IN,
  input wire logic INT_EN_CLEAR_IN,
  input wire logic PUSH_IN,
  input wire logic [PC_W-1:0] PUSH_PC_IN,
  output logic OP_READY_OUT,
  output logic DONE_OUT,
  output logic [7:0] ACC_OUT,
  output logic ZERO_OUT,
  output logic INT_EN_OUT,
  output logic [PC_W-1:0] PC_OUT,
  output logic PC_LOAD_OUT,
  output logic IRQ_TAKE_OUT,
  output logic [ADDR_W-1:0] MEM_ADDR_OUT,
  output logic MEM_RE_OUT,
  output logic MEM_WE_OUT,
  output logic [7:0] MEM_WDATA_OUT,
  output logic [$clog2(STACK_DEPTH)-1:0] SP_OUT
);

  localparam int SP_W = $clog2(STACK_DEPTH);
  localparam logic [SP_W-1:0] SP_ONE = SP_W'(1);

  logic [1:0] rst_sync_reg;
  logic rst_n;
  orre_state_t state_reg, state_next;
  orre_op_t op, op_reg;
  logic accept, is_exit, is_mem, push_take, take_irq;
  logic [7:0] imm_reg, acc_reg, or_res, rot_res, mem_res, wdata_reg;
  logic zero_reg, int_en_reg, pc_load_reg, irq_take_reg, done_reg;
  logic re_reg, we_reg, ready_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [PC_W-1:0] pc_reg, stk_rd_data, stk_wr_data;
  logic [SP_W-1:0] sp_reg, stk_rd_addr;
  logic stk_wr_en;

  // Reset is released through two flops so its removal is clean.
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_sync_reg <= ORRE_RST_SYNC_RST;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Decode of the offered instruction and the shared data paths.
  assign op = orre_op_t'(OP_CODE_IN);
  assign accept = OP_VALID_IN && (state_reg == ORRE_ST_IDLE);
  assign is_exit = accept && (op == ORRE_OP_SUBROUTINE_EXIT ||
                             op == ORRE_OP_SUBROUTINE_EXIT_IMM ||
                             op == ORRE_OP_INTERRUPT_EXIT);
  assign is_mem = accept && (op == ORRE_OP_OR_INTO_MEMORY ||
                             op == ORRE_OP_ROTATE_LEFT);
  // A push is only taken when no instruction competes for the stack.
  assign push_take = PUSH_IN && !OP_VALID_IN && (state_reg == ORRE_ST_IDLE);
  assign take_irq = (state_reg == ORRE_ST_POP) && IRQ_PENDING_IN &&
                    (op_reg == ORRE_OP_INTERRUPT_EXIT); // see RULE7
  assign or_res = acc_reg | MEM_RDATA_IN; // see RULE2
  assign rot_res = {MEM_RDATA_IN[ORRE_MSB-1:0], MEM_RDATA_IN[ORRE_MSB]}; // see RULE8
  assign mem_res = (op_reg == ORRE_OP_OR_INTO_MEMORY) ? or_res : rot_res;

  // Stack port: the top entry sits one below the pointer.
  assign stk_rd_addr = sp_reg - SP_ONE;
  assign stk_wr_en = push_take || take_irq;
  // The restored address is pushed again so the handler returns there.
  assign stk_wr_data = take_irq ? stk_rd_data : PUSH_PC_IN;

  orre_stack_mem #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(PC_W),
    .AW(SP_W)
  ) u_stack (
    .clk_in(CLOCK_IN),
    .rst_n_in(rst_n),
    .wr_en_in(stk_wr_en),
    .wr_addr_in(sp_reg),
    .wr_data_in(stk_wr_data),
    .rd_en_in(is_exit),
    .rd_addr_in(stk_rd_addr),
    .rd_data_out(stk_rd_data)
  );

  // Next state of the sequencer.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ORRE_ST_IDLE: begin
        if (is_mem) begin
          state_next = ORRE_ST_MREAD;
        end else if (is_exit) begin
          state_next = ORRE_ST_POP;
        end
      end
      ORRE_ST_MREAD: state_next = ORRE_ST_MCAPT;
      ORRE_ST_MCAPT: state_next = ORRE_ST_MWRITE;
      ORRE_ST_MWRITE: state_next = ORRE_ST_IDLE;
      ORRE_ST_POP: state_next = ORRE_ST_IDLE;
      default: state_next = ORRE_ST_IDLE;
    endcase
  end

  // Sequencer state and ready flag.
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ORRE_ST_IDLE;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= (state_next == ORRE_ST_IDLE);
    end
  end

  // Operands are held for the multi-cycle instructions.
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      op_reg <= ORRE_OP_OR_IMM;
      imm_reg <= ORRE_ACC_RST;
      addr_reg <= '0;
    end else if (accept) begin
      op_reg <= op;
      imm_reg <= OP_IMM_IN;
      addr_reg <= OP_ADDR_IN;
    end
  end

  // Stack pointer: one pop per return, one push per call or irq entry.
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      sp_reg <= '0;
    end else if (is_exit) begin
      sp_reg <= sp_reg - SP_ONE; // see RULE10
    end else if (stk_wr_en) begin
      sp_reg <= sp_reg + SP_ONE;
    end
  end
  // Program counter load; a pending interrupt at interrupt_exit redirects to its vector.
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg <= ORRE_PC_RST;
      pc_load_reg <= 1'b0;
      irq_take_reg <= 1'b0;
    end else begin
      pc_load_reg <= (state_reg == ORRE_ST_POP); // see RULE4
      irq_take_reg <= take_irq; // see RULE7
      if (take_irq) begin
        pc_reg <= IRQ_VECTOR_IN; // see RULE7
      end else if (state_reg == ORRE_ST_POP) begin
        pc_reg <= stk_rd_data; // see RULE4
      end
    end
  end
  // Accumulator; memory-side instructions never touch it (see RULE3).
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= ORRE_ACC_RST;
    end else if (accept && op == ORRE_OP_OR_IMM) begin
      acc_reg <= acc_reg | OP_IMM_IN; // see RULE1
    end else if (state_reg == ORRE_ST_POP &&
                 op_reg == ORRE_OP_SUBROUTINE_EXIT_IMM) begin
      acc_reg <= imm_reg; // see RULE5
    end
  end
  // Zero flag follows only the two OR instructions.
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      zero_reg <= ORRE_ZERO_RST;
    end else if (accept && op == ORRE_OP_OR_IMM) begin
      zero_reg <= ((acc_reg | OP_IMM_IN) == 8'h00); // see RULE1
    end else if (state_reg == ORRE_ST_MCAPT &&
                 op_reg == ORRE_OP_OR_INTO_MEMORY) begin
      zero_reg <= (or_res == 8'h00); // see RULE2
    end
  end
  // Master interrupt enable; the set from interrupt_exit beats a clear.
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      int_en_reg <= ORRE_INT_EN_RST;
    end else if (state_reg == ORRE_ST_POP &&
                 op_reg == ORRE_OP_INTERRUPT_EXIT) begin
      int_en_reg <= 1'b1; // see RULE6
    end else if (INT_EN_CLEAR_IN) begin
      int_en_reg <= 1'b0;
    end
  end
  // Memory strobes: read request, then write-back of the result.
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      re_reg <= 1'b0;
      we_reg <= 1'b0;
      wdata_reg <= 8'h00;
    end else begin
      re_reg <= (state_next == ORRE_ST_MREAD);
      we_reg <= (state_reg == ORRE_ST_MCAPT); // see RULE9
      if (state_reg == ORRE_ST_MCAPT) begin
        wdata_reg <= mem_res; // see RULE2, see RULE8
      end
    end
  end
  // Completion pulse; unused codes complete at once and do nothing.
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (accept && !is_mem && !is_exit) ||
                  (state_reg == ORRE_ST_MCAPT) || (state_reg == ORRE_ST_POP);
    end
  end
  assign OP_READY_OUT = ready_reg;
  assign DONE_OUT = done_reg;
  assign ACC_OUT = acc_reg;
  assign ZERO_OUT = zero_reg;
  assign INT_EN_OUT = int_en_reg;
  assign PC_OUT = pc_reg;
  assign PC_LOAD_OUT = pc_load_reg;
  assign IRQ_TAKE_OUT = irq_take_reg;
  assign MEM_ADDR_OUT = addr_reg;
  assign MEM_RE_OUT = re_reg;
  assign MEM_WE_OUT = we_reg;
  assign MEM_WDATA_OUT = wdata_reg;
  assign SP_OUT = sp_reg;
  // Checks of the instruction effects against their causes.
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!rst_n);
  sequence s_take(orre_op_t code);
    accept && op == code;
  endsequence
  sequence s_exit_any;
    accept && is_exit;
  endsequence
  a_or_imm_acc: assert property ( // see RULE1
    s_take(ORRE_OP_OR_IMM) |=> acc_reg == ($past(acc_reg) | $past(OP_IMM_IN))
      && zero_reg == (acc_reg == 8'h00))
    else $error("OR immediate result or zero flag wrong.");
  a_or_mem_write: assert property ( // see RULE2
    s_take(ORRE_OP_OR_INTO_MEMORY) |=> ##1 (state_reg == ORRE_ST_MCAPT) ##1
      (we_reg && wdata_reg == ($past(acc_reg) | $past(MEM_RDATA_IN)) &&
      zero_reg == (wdata_reg == 8'h00)))
    else $error("or_into_memory write-back wrong.");
  a_or_mem_acc_kept: assert property ( // see RULE3
    s_take(ORRE_OP_OR_INTO_MEMORY) |=> $stable(acc_reg) [*3])
    else $error("or_into_memory changed the accumulator.");
  a_exit_pc_load: assert property ( // see RULE4
    s_take(ORRE_OP_SUBROUTINE_EXIT) |=> (state_reg == ORRE_ST_POP) ##1
      (pc_load_reg && pc_reg == $past(stk_rd_data) && $stable(zero_reg)))
    else $error("subroutine_exit did not load PC from stack.");
  a_exit_imm_acc: assert property ( // see RULE5
    s_take(ORRE_OP_SUBROUTINE_EXIT_IMM) |=> ##1
      (acc_reg == $past(OP_IMM_IN, 2) && zero_reg == $past(zero_reg, 2)))
    else $error("Exit with immediate did not load accumulator.");
  a_iexit_en_set: assert property ( // see RULE6
    s_take(ORRE_OP_INTERRUPT_EXIT) |=> ##1
      (int_en_reg && pc_load_reg && zero_reg == $past(zero_reg, 2)))
    else $error("interrupt_exit did not set the interrupt enable.");
  a_iexit_irq_first: assert property ( // see RULE7
    (state_reg == ORRE_ST_POP && op_reg == ORRE_OP_INTERRUPT_EXIT &&
     IRQ_PENDING_IN) |=> irq_take_reg && pc_reg == $past(IRQ_VECTOR_IN)
      && sp_reg == $past(sp_reg) + SP_ONE)
    else $error("Pending interrupt not serviced at interrupt_exit.");
  a_rot_left_data: assert property ( // see RULE8
    (state_reg == ORRE_ST_MCAPT && op_reg == ORRE_OP_ROTATE_LEFT) |=>
      wdata_reg == {$past(MEM_RDATA_IN[6:0]), $past(MEM_RDATA_IN[7])})
    else $error("rotate_left result wrong.");
  a_rot_left_keep: assert property ( // see RULE9
    s_take(ORRE_OP_ROTATE_LEFT) |=> ($stable(acc_reg) && $stable(zero_reg))
      [*3] ##0 (we_reg && MEM_ADDR_OUT == $past(OP_ADDR_IN, 3)))
    else $error("rotate_left write-back or flags wrong.");
  a_exit_pop_one: assert property ( // see RULE10
    s_exit_any |=> sp_reg == $past(sp_reg) - SP_ONE)
    else $error("Return did not pop exactly one stack entry.");

endmodule // orre_exec

// [logic/orre_pkg.sv]
// Constants and types shared by the OR, return and rotate execution unit.
package orre_pkg;

  // Data path widths.
  localparam int ORRE_DATA_W = 8;
  localparam int ORRE_ADDR_W = 8;
  localparam int ORRE_PC_W = 13;
  localparam int ORRE_STACK_DEPTH = 8;

  // Values after reset.
  localparam logic [7:0] ORRE_ACC_RST = 8'h00;
  localparam logic ORRE_ZERO_RST = 1'h0;
  localparam logic ORRE_INT_EN_RST = 1'h0;
  localparam logic [12:0] ORRE_PC_RST = 13'h0000;
  localparam logic [1:0] ORRE_RST_SYNC_RST = 2'h0;

  // Bit positions used by the rotate.
  localparam int ORRE_MSB = 7;

  // Instruction codes presented on the operation port.
  typedef enum logic [2:0] {
    ORRE_OP_OR_IMM = 3'h0,
    ORRE_OP_OR_INTO_MEMORY = 3'h1,
    ORRE_OP_SUBROUTINE_EXIT = 3'h2,
    ORRE_OP_SUBROUTINE_EXIT_IMM = 3'h3,
    ORRE_OP_INTERRUPT_EXIT = 3'h4,
    ORRE_OP_ROTATE_LEFT = 3'h5
  } orre_op_t;

  // Sequencer states.
  typedef enum logic [2:0] {
    ORRE_ST_IDLE = 3'h0,
    ORRE_ST_MREAD = 3'h1,
    ORRE_ST_MCAPT = 3'h2,
    ORRE_ST_MWRITE = 3'h3,
    ORRE_ST_POP = 3'h4
  } orre_state_t;

endpackage

// [logic/orre_stack_mem.sv]
// Hardware return-address stack storage with registered read data.
`timescale 1ns/1ps
module orre_stack_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 13,
  parameter int AW = 3
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic rd_en_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  // Storage has no reset; a return before any push reads stale data.
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end

  // Read data is registered so it is valid the cycle after the request.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= '0;
    end else if (rd_en_in) begin
      rd_data_out <= mem_reg[rd_addr_in];
    end
  end

endmodule // orre_stack_mem
